/* pkg/cst_consts.svh */
// token values, bit counts and crc constants of the status/token block
`ifndef CST_CONSTS_SVH
`define CST_CONSTS_SVH

`define CST_TOK_START    8'hFE
`define CST_TOK_MSTART   8'hFC
`define CST_IDLE_BYTE    8'hFF
`define CST_ERRTOK_HI    4'h0
`define CST_R1_TOP       1'b0
`define CST_CRC_POLY     16'h1021
`define CST_CRC_INIT     16'h0000
`define CST_BIT_FIRST    3'h7
`define CST_BIT_LAST     3'h0
`define CST_RXBIT_FIRST  3'h0
`define CST_RXBIT_LAST   3'h7
`define CST_CNT_ZERO     12'h000
`define CST_CNT_ONE      12'h001
`define CST_CRC_BITS_M1  12'h00F

`endif

/* pkg/cst_pkg.sv */
// types shared by the status/token block
package cst_pkg;

  typedef enum logic [1:0] {
    CST_K_R1   = 2'h0,
    CST_K_R2   = 2'h1,
    CST_K_ERR  = 2'h2,
    CST_K_DATA = 2'h3
  } cst_kind_t;

  typedef struct packed {
    logic out_of_range;
    logic csd_overwrite;
    logic addr_err;
    logic erase_seq_err;
    logic erase_param;
    logic param_err;
    logic wp_violation;
    logic com_crc_err;
    logic illegal_cmd;
    logic ecc_fail;
    logic controller_fault_flag;
    logic gen_err;
    logic wp_erase_skip;
    logic lock_fail;
    logic erase_reset;
  } cst_flags_t;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_HEAD  = 3'b001,
    TX_START = 3'b011,
    TX_DATA  = 3'b010,
    TX_CRC   = 3'b110
  } cst_tx_st_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_DATA = 2'b01,
    RX_CRC  = 2'b11
  } cst_rx_st_t;

endpackage

/* core/cst_status_tokens.sv */
// spi-mode card status flags, responses, read-error and data tokens
// Summary of operation
// - data token carries block-length user bytes right after the start byte
// - last two token bytes are the data crc; sent on reads, checked on writes
// - failed read sends a one-byte read-error token instead of a data token
// - read-error token low four bits: out-of-range, ecc, fault, general
// - every error flag clears once a response carrying it went out
// - card-locked follows lock state, never cleared by a read
// - out-of-range set on bad argument; and error token; read clears
// - address error on misaligned address
// - erase sequence error read clears
// - erase parameter error only read clears
// - parameter error read clears
// - write-protect violation on program of protected block; only
// - command crc error read clears
// - illegal command
// - ecc failure and read-error token
// - controller fault and general error and error token; read clears
// - protected erase skip only
// - lock/unlock failure read clears
// - erase reset
// - idle indicator follows init state
// - descriptor overwrite
// - data tokens are 4 to 4099 bytes (block length 0 gives 4096 user bytes), each byte msb first
`timescale 1ns/1ns
`include "cst_consts.svh"

module cst_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

module cst_status_tokens
  import cst_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_b_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  input  wire cst_flags_t  err_set_i,
  input  wire logic        card_idle_i,
  input  wire logic        card_locked_i,
  input  wire logic [11:0] blk_len_i,
  input  wire logic        tx_req_i,
  input  wire cst_kind_t   tx_kind_i,
  output logic             tx_busy_o,
  input  wire logic [7:0]  tx_data_i,
  output logic             tx_data_rd_o,
  input  wire logic        rx_arm_i,
  output logic [7:0]       rx_data_o,
  output logic             rx_valid_o,
  output logic             rx_done_o,
  output logic             rx_crc_ok_o,
  output cst_flags_t       flags_o
);

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic        b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CST_CRC_POLY : 16'h0000);
  endfunction

  // flags that each answer format reports, hence clears
  function automatic cst_flags_t clr_mask(input cst_kind_t k);
    cst_flags_t m;
    m = '0;
    if (k == CST_K_R2) begin
      m = '1;
    end else if (k == CST_K_R1) begin
      m.param_err     = 1'b1;
      m.addr_err      = 1'b1;
      m.erase_seq_err = 1'b1;
      m.com_crc_err   = 1'b1;
      m.illegal_cmd   = 1'b1;
      m.erase_reset   = 1'b1;
    end else if (k == CST_K_ERR) begin
      m.out_of_range          = 1'b1;
      m.ecc_fail              = 1'b1;
      m.controller_fault_flag = 1'b1;
      m.gen_err               = 1'b1;
    end
    clr_mask = m;
  endfunction

  // system domain
  cst_flags_t  flags_q;
  cst_flags_t  clr_q;
  cst_kind_t   kind_q;
  logic [15:0] head_q;
  logic [11:0] len_q;
  logic [7:0]  txb_q;
  logic        busy_q;
  logic        req_tgl_q;
  logic [7:0]  rx_data_q;
  logic        rx_valid_q;
  logic        rx_done_q;
  logic        rx_ok_q;
  logic [3:0]  sys_tg_s;
  logic [3:0]  sys_tg_q;
  logic [3:0]  sys_ev;
  logic        take;
  logic [7:0]  r1_byte;
  logic [7:0]  r2_byte;
  logic [7:0]  err_byte;

  // link domain
  logic        lrst_b;
  logic [1:0]  lnk_s;
  logic        req_seen_q;
  cst_tx_st_t  tx_st_q;
  logic [7:0]  sh_q;
  logic [2:0]  bit_q;
  logic [11:0] cnt_q;
  logic [15:0] crc_q;
  logic [15:0] crc_nx;
  logic        need_tgl_q;
  logic        done_tgl_q;
  logic        tx_ok_q;
  cst_rx_st_t  rx_st_q;
  logic [7:0]  rsh_q;
  logic [2:0]  rbit_q;
  logic [11:0] rcnt_q;
  logic [15:0] rcrc_q;
  logic [15:0] rcrc_nx;
  logic [7:0]  rbyte_q;
  logic        rxb_tgl_q;
  logic        rxd_tgl_q;
  logic        rok_q;
  logic [7:0]  rx_in;
  logic [11:0] len_m1;
  logic [2:0]  hbit_q;

  cst_sync #(.W(4)) u_sys_sync (
    .clk_i   (sys_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({rxd_tgl_q, rxb_tgl_q, need_tgl_q, done_tgl_q}),
    .q_o     (sys_tg_s)
  );

  // [0] done, [1] byte needed, [2] rx byte, [3] rx block end
  assign sys_ev = sys_tg_s ^ sys_tg_q;
  assign take   = tx_req_i && !busy_q;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sys_tg_q <= 4'h0;
    end else begin
      sys_tg_q <= sys_tg_s;
    end
  end

  // answer bytes from live flags; idle and locked follow card state
  assign r1_byte = {`CST_R1_TOP, flags_q.param_err, flags_q.addr_err,
                    flags_q.erase_seq_err, flags_q.com_crc_err,
                    flags_q.illegal_cmd, flags_q.erase_reset,
                    card_idle_i};
  assign r2_byte = {flags_q.out_of_range | flags_q.csd_overwrite,
                    flags_q.erase_param, flags_q.wp_violation,
                    flags_q.ecc_fail, flags_q.controller_fault_flag,
                    flags_q.gen_err,
                    flags_q.wp_erase_skip | flags_q.lock_fail,
                    card_locked_i};
  assign err_byte = {`CST_ERRTOK_HI, flags_q.out_of_range, flags_q.ecc_fail,
                     flags_q.controller_fault_flag,
                     flags_q.gen_err};

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      busy_q    <= 1'b0;
      req_tgl_q <= 1'b0;
      kind_q    <= CST_K_R1;
      head_q    <= 16'h0000;
      clr_q     <= '0;
    end else if (take) begin
      busy_q    <= 1'b1;
      req_tgl_q <= ~req_tgl_q;
      kind_q    <= tx_kind_i;
      // execution-time flags show up in the next answer whose format carries them
      head_q    <= (tx_kind_i == CST_K_R2)  ? {r1_byte, r2_byte} :
                   (tx_kind_i == CST_K_ERR) ? {err_byte, 8'h00}  :
                                              {r1_byte, 8'h00};
      clr_q     <= clr_mask(tx_kind_i) & flags_q;
    end else if (sys_ev[0]) begin
      busy_q    <= 1'b0;
    end
  end

  // sticky flags; a new set wins over the clear of a report
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      flags_q <= '0;
    end else if (sys_ev[0] && tx_ok_q) begin
      flags_q <= (flags_q & ~clr_q) | err_set_i;
    end else begin
      flags_q <= flags_q | err_set_i;
    end
  end

  // block length tracks the input while nothing uses it
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      len_q <= `CST_CNT_ONE;
    end else if (!busy_q && !take && !rx_arm_i) begin
      len_q <= blk_len_i;
    end
  end

  // next user byte, fetched a whole byte time ahead of its use
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      txb_q <= 8'h00;
    end else if (sys_ev[1]) begin
      txb_q <= tx_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rx_data_q  <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_done_q  <= 1'b0;
      rx_ok_q    <= 1'b0;
    end else begin
      rx_valid_q <= sys_ev[2];
      rx_done_q  <= sys_ev[3];
      if (sys_ev[2]) begin
        rx_data_q <= rbyte_q;
      end
      if (sys_ev[3]) begin
        rx_ok_q <= rok_q;
      end
    end
  end

  assign tx_busy_o    = busy_q;
  assign tx_data_rd_o = sys_ev[1];
  assign rx_data_o    = rx_data_q;
  assign rx_valid_o   = rx_valid_q;
  assign rx_done_o    = rx_done_q;
  assign rx_crc_ok_o  = rx_ok_q;
  assign flags_o      = flags_q;

  // link domain logic
  cst_sync #(.W(1)) u_rst_sync (
    .clk_i   (sclk_i),
    .rst_b_i (1'b1),
    .d_i     (rst_b_i),
    .q_o     (lrst_b)
  );

  cst_sync #(.W(2)) u_lnk_sync (
    .clk_i   (sclk_i),
    .rst_b_i (lrst_b),
    .d_i     ({rx_arm_i, req_tgl_q}),
    .q_o     (lnk_s)
  );

  assign len_m1 = len_q - `CST_CNT_ONE;
  assign crc_nx = crc_step(crc_q, sh_q[7]);

  always_ff @(posedge sclk_i) begin
    if (!lrst_b) begin
      tx_st_q    <= TX_IDLE;
      sh_q       <= `CST_IDLE_BYTE;
      bit_q      <= `CST_BIT_LAST;
      cnt_q      <= `CST_CNT_ZERO;
      req_seen_q <= 1'b0;
      need_tgl_q <= 1'b0;
      done_tgl_q <= 1'b0;
      tx_ok_q    <= 1'b0;
    end else if (cs_b_i) begin
      // frame dropped mid-answer: release the system side unreported
      if (tx_st_q != TX_IDLE) begin
        done_tgl_q <= ~done_tgl_q;
        tx_ok_q    <= 1'b0;
      end
      tx_st_q <= TX_IDLE;
      sh_q    <= `CST_IDLE_BYTE;
    end else if (tx_st_q == TX_IDLE) begin
      if (lnk_s[0] != req_seen_q) begin
        req_seen_q <= lnk_s[0];
        bit_q      <= `CST_BIT_FIRST;
        cnt_q      <= `CST_CNT_ZERO;
        if (kind_q == CST_K_DATA) begin
          tx_st_q    <= TX_START;
          sh_q       <= `CST_TOK_START;
          need_tgl_q <= ~need_tgl_q;
        end else begin
          tx_st_q <= TX_HEAD;
          sh_q    <= head_q[15:8];
        end
      end
    end else if (bit_q != `CST_BIT_LAST) begin
      sh_q  <= {sh_q[6:0], 1'b1};
      bit_q <= bit_q - 3'h1;
    end else begin
      bit_q <= `CST_BIT_FIRST;
      case (tx_st_q)
        TX_HEAD: begin
          if (kind_q == CST_K_R2 && cnt_q == `CST_CNT_ZERO) begin
            sh_q  <= head_q[7:0];
            cnt_q <= `CST_CNT_ONE;
          end else begin
            // completes only while the host keeps clocking
            tx_st_q    <= TX_IDLE;
            sh_q       <= `CST_IDLE_BYTE;
            done_tgl_q <= ~done_tgl_q;
            tx_ok_q    <= 1'b1;
          end
        end
        TX_START: begin
          tx_st_q <= TX_DATA;
          sh_q    <= txb_q;
          cnt_q   <= `CST_CNT_ZERO;
          if (len_m1 != `CST_CNT_ZERO) begin
            need_tgl_q <= ~need_tgl_q;
          end
        end
        TX_DATA: begin
          if (cnt_q == len_m1) begin
            tx_st_q <= TX_CRC;
            sh_q    <= crc_nx[15:8];
            cnt_q   <= `CST_CNT_ZERO;
          end else begin
            sh_q  <= txb_q;
            cnt_q <= cnt_q + `CST_CNT_ONE;
            if ((cnt_q + `CST_CNT_ONE) != len_m1) begin
              need_tgl_q <= ~need_tgl_q;
            end
          end
        end
        TX_CRC: begin
          if (cnt_q == `CST_CNT_ZERO) begin
            sh_q  <= crc_q[7:0];
            cnt_q <= `CST_CNT_ONE;
          end else begin
            tx_st_q    <= TX_IDLE;
            sh_q       <= `CST_IDLE_BYTE;
            done_tgl_q <= ~done_tgl_q;
            tx_ok_q    <= 1'b1;
          end
        end
        default: begin
          tx_st_q <= TX_IDLE;
          sh_q    <= `CST_IDLE_BYTE;
        end
      endcase
    end
  end

  // data crc runs over user bytes only
  always_ff @(posedge sclk_i) begin
    if (!lrst_b || tx_st_q == TX_START) begin
      crc_q <= `CST_CRC_INIT;
    end else if (tx_st_q == TX_DATA) begin
      crc_q <= crc_nx;
    end
  end

  // host samples on the rising edge after the card updates the line
  assign miso_o    = sh_q[7];
  assign miso_oe_o = ~cs_b_i;

  // write data token receiver
  assign rx_in   = {rsh_q[6:0], mosi_i};

  // bit position in the byte, counted from select; a bit-aligned hunt
  // would take the start-token pattern one bit early inside FC
  always_ff @(posedge sclk_i or posedge cs_b_i) begin
    if (cs_b_i || !lrst_b) begin
      hbit_q <= `CST_RXBIT_FIRST;
    end else begin
      hbit_q <= hbit_q + 3'h1;
    end
  end
  assign rcrc_nx = crc_step(rcrc_q, mosi_i);

  always_ff @(posedge sclk_i) begin
    if (!lrst_b) begin
      rxb_tgl_q <= 1'b0;
      rxd_tgl_q <= 1'b0;
      rok_q     <= 1'b0;
      rbyte_q   <= 8'h00;
    end else if (!cs_b_i && rx_st_q == RX_DATA
                 && rbit_q == `CST_RXBIT_LAST) begin
      rbyte_q   <= rx_in;
      rxb_tgl_q <= ~rxb_tgl_q;
    end else if (!cs_b_i && rx_st_q == RX_CRC
                 && rcnt_q == `CST_CRC_BITS_M1) begin
      rok_q     <= (rcrc_nx == `CST_CRC_INIT);
      rxd_tgl_q <= ~rxd_tgl_q;
    end
  end

  always_ff @(posedge sclk_i) begin
    if (!lrst_b || cs_b_i || !lnk_s[1] || tx_st_q != TX_IDLE) begin
      rx_st_q <= RX_HUNT;
      rsh_q   <= `CST_IDLE_BYTE;
      rbit_q  <= `CST_RXBIT_FIRST;
      rcnt_q  <= `CST_CNT_ZERO;
      rcrc_q  <= `CST_CRC_INIT;
    end else begin
      rsh_q <= rx_in;
      case (rx_st_q)
        RX_HUNT: begin
          rcrc_q <= `CST_CRC_INIT;
          if (hbit_q == `CST_RXBIT_LAST
              && (rx_in == `CST_TOK_START
                  || rx_in == `CST_TOK_MSTART)) begin
            rx_st_q <= RX_DATA;
            rbit_q  <= `CST_RXBIT_FIRST;
            rcnt_q  <= `CST_CNT_ZERO;
          end
        end
        RX_DATA: begin
          rcrc_q <= rcrc_nx;
          rbit_q <= rbit_q + 3'h1;
          if (rbit_q == `CST_RXBIT_LAST) begin
            if (rcnt_q == len_m1) begin
              rx_st_q <= RX_CRC;
              rcnt_q  <= `CST_CNT_ZERO;
            end else begin
              rcnt_q <= rcnt_q + `CST_CNT_ONE;
            end
          end
        end
        RX_CRC: begin
          rcrc_q <= rcrc_nx;
          if (rcnt_q == `CST_CRC_BITS_M1) begin
            rx_st_q <= RX_HUNT;
            rsh_q   <= `CST_IDLE_BYTE;
          end else begin
            rcnt_q <= rcnt_q + `CST_CNT_ONE;
          end
        end
        default: begin
          rx_st_q <= RX_HUNT;
        end
      endcase
    end
  end

endmodule

/* testbench/cst_status_tokens_asserts.sv */
// concurrent checks on the status/token block ports
`timescale 1ns/1ns
module cst_status_tokens_asserts
  import cst_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       rst_b_i,
  input wire logic       cs_b_i,
  input wire logic       miso_oe_o,
  input wire cst_flags_t err_set_i,
  input wire cst_flags_t flags_o,
  input wire logic       tx_req_i,
  input wire logic       tx_busy_o,
  input wire logic       tx_data_rd_o,
  input wire logic       rx_valid_o,
  input wire logic       rx_done_o,
  input wire logic       rx_crc_ok_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_flag_sets: assert property (
    err_set_i != '0 |=> ($past(err_set_i) & ~flags_o) == '0)
    else $error("flag pulse did not set its flag");
  a_flags_no_drop: assert property (
    !tx_busy_o [*3] |-> (~flags_o & $past(flags_o)) == '0)
    else $error("flag cleared without a response");
  a_take_busy: assert property (
    tx_req_i && !tx_busy_o |=> tx_busy_o)
    else $error("request not taken");
  a_busy_min: assert property (
    $rose(tx_busy_o) |=> tx_busy_o [*8])
    else $error("answer ended too early");
  a_rd_pulse: assert property (
    tx_data_rd_o |=> !tx_data_rd_o)
    else $error("byte fetch longer than one cycle");
  a_rd_in_busy: assert property (
    tx_data_rd_o |-> tx_busy_o)
    else $error("byte fetch outside an answer");
  a_rx_pulse: assert property (
    rx_valid_o |=> !rx_valid_o)
    else $error("received byte strobe too long");
  a_done_pulse: assert property (
    rx_done_o |=> !rx_done_o)
    else $error("block done strobe too long");
  a_oe_cs: assert property (
    miso_oe_o == !cs_b_i)
    else $error("output enable does not follow select");

  c_done: cover property ($fell(tx_busy_o));
  c_rx_ok: cover property (rx_done_o && rx_crc_ok_o);
  c_rx_bad: cover property (rx_done_o && !rx_crc_ok_o);
  c_fetch: cover property (tx_data_rd_o);
endmodule

bind cst_status_tokens cst_status_tokens_asserts chk_u (
  .sys_clk_i    (sys_clk_i),
  .rst_b_i      (rst_b_i),
  .cs_b_i       (cs_b_i),
  .miso_oe_o    (miso_oe_o),
  .err_set_i    (err_set_i),
  .flags_o      (flags_o),
  .tx_req_i     (tx_req_i),
  .tx_busy_o    (tx_busy_o),
  .tx_data_rd_o (tx_data_rd_o),
  .rx_valid_o   (rx_valid_o),
  .rx_done_o    (rx_done_o),
  .rx_crc_ok_o  (rx_crc_ok_o)
);

/* testbench/cst_host_model.sv */
// host side of the spi link: clocks, selects and shifts bytes
`timescale 1ns/1ns
module cst_host_model #(
  parameter int POST_RESPONSE_CLOCK_COUNT = 8
) (
  output logic      sclk_o,
  output logic      cs_b_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    mosi_o = 1'b0;
  end
  // mode 0 bit: mosi set while low, miso taken before rise
  task automatic bit_x(input logic b, output logic r);
    mosi_o = b;
    #80;
    r = miso_i;
    sclk_o = 1'b1;
    #80;
    sclk_o = 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bit_x(t[i], r[i]);
    end
  endtask
  // clocks with select high, released line toggles
  task automatic idle(input int n);
    repeat (n) begin
      mosi_o = ~mosi_o;
      #80;
      sclk_o = 1'b1;
      #80;
      sclk_o = 1'b0;
    end
  endtask
  task automatic sel;
    cs_b_o = 1'b0;
    #80;
  endtask
  task automatic desel;
    logic d;
    repeat (POST_RESPONSE_CLOCK_COUNT) bit_x(1'b1, d);
    cs_b_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask
  // clock until the first low bit on miso
  task automatic hunt;
    logic b;
    int   n;
    b = 1'b1;
    n = 0;
    while (b !== 1'b0 && n < 64) begin
      bit_x(1'b1, b);
      n++;
    end
  endtask
  task automatic get_r(output logic [7:0] r);
    hunt();
    r[7] = 1'b0;
    for (int i = 6; i >= 0; i--) begin
      bit_x(1'b1, r[i]);
    end
  endtask
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d);
    for (int i = 7; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction
endmodule

/* testbench/card_spi_status_tokens_test.sv */
// self-checking bench for the status and token block
`timescale 1ns/1ns
module card_spi_status_tokens_test
  import cst_pkg::*;
;
  logic        sys_clk_i;
  logic        rst_b_i;
  logic        sclk, cs_b, mosi, miso, miso_oe;
  cst_flags_t  err_set, flags;
  cst_kind_t   kind;
  logic        idle, locked, req, busy, rd, arm, rx_v, rx_d, rx_ok;
  logic        ok_seen;
  logic [11:0] blk_len;
  logic [7:0]  tx_data, rx_byte, rd_cnt;
  logic [7:0]  rxq[$];
  int          n_errors, samples_checked, cycles, n_done;

  function automatic logic [7:0] pat(input logic [7:0] i);
    return i * 8'h3B + 8'h11;
  endfunction
  assign tx_data = pat(rd_cnt);

  cst_status_tokens dut_u (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk),
    .cs_b_i(cs_b), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .err_set_i(err_set), .card_idle_i(idle), .card_locked_i(locked),
    .blk_len_i(blk_len), .tx_req_i(req), .tx_kind_i(kind),
    .tx_busy_o(busy), .tx_data_i(tx_data), .tx_data_rd_o(rd),
    .rx_arm_i(arm), .rx_data_o(rx_byte), .rx_valid_o(rx_v),
    .rx_done_o(rx_d), .rx_crc_ok_o(rx_ok), .flags_o(flags));
  cst_host_model host_u (
    .sclk_o(sclk), .cs_b_o(cs_b), .mosi_o(mosi), .miso_i(miso));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (rd === 1'b1) rd_cnt <= rd_cnt + 8'h01;
    if (rx_v === 1'b1) rxq.push_back(rx_byte);
    if (rx_d === 1'b1) begin
      n_done++;
      ok_seen <= rx_ok;
    end
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkf(input cst_flags_t g, input cst_flags_t e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t flags %h exp %h", $time, g, e);
    end
  endtask
  task automatic pulse(input cst_flags_t f);
    @(negedge sys_clk_i);
    err_set = f;
    @(negedge sys_clk_i);
    err_set = '0;
  endtask
  task automatic ask(input cst_kind_t k);
    @(negedge sys_clk_i);
    kind = k;
    req = 1'b1;
    @(negedge sys_clk_i);
    req = 1'b0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk8({7'h00, busy}, 8'h00);
  endtask
  // one answer of kind k, its bytes and the flags left after it
  task automatic resp(input cst_kind_t k, input logic [7:0] e1,
                      input logic [7:0] e2, input cst_flags_t ef);
    logic [7:0] b;
    host_u.sel();
    ask(k);
    host_u.get_r(b);
    chk8(b, e1);
    if (k == CST_K_R2) begin
      host_u.byte_x(8'hFF, b);
      chk8(b, e2);
    end
    host_u.desel();
    wait_idle();
    @(negedge sys_clk_i);
    chkf(flags, ef);
  endtask

  // param, addr, illegal out of range kept
  task automatic t_r1;
    pulse(15'h5240);
    resp(CST_K_R1, 8'h65, 8'h00, 15'h4000);
  endtask
  task automatic t_r2;
    pulse(15'h0CA3);
    @(negedge sys_clk_i);
    locked = 1'b1;
    resp(CST_K_R2, 8'h1B, 8'hD3, 15'h0000);
    idle = 1'b0;
    resp(CST_K_R2, 8'h00, 8'h01, 15'h0000);
    locked = 1'b0;
  endtask
  // token clears its four only; violation left
  task automatic t_err;
    pulse(15'h4118);
    resp(CST_K_ERR, 8'h0B, 8'h00, 15'h0100);
    pulse(15'h2004);
    resp(CST_K_R2, 8'h00, 8'hA2, 15'h0000);
  endtask
  task automatic t_data(input logic [11:0] len);
    logic [7:0]  b;
    logic [15:0] c;
    c = 16'h0000;
    @(negedge sys_clk_i);
    blk_len = len;
    rd_cnt = 8'h00;
    host_u.sel();
    ask(CST_K_DATA);
    host_u.hunt();
    for (int i = 0; i < len; i++) begin
      host_u.byte_x(8'hFF, b);
      chk8(b, pat(8'(i)));
      c = host_u.crc_byte(c, pat(8'(i)));
    end
    host_u.byte_x(8'hFF, b);
    chk8(b, c[15:8]);
    host_u.byte_x(8'hFF, b);
    chk8(b, c[7:0]);
    host_u.desel();
    wait_idle();
    chk8(rd_cnt, len[7:0]);
  endtask
  task automatic t_write(input logic bad);
    logic [7:0]  b;
    logic [15:0] c;
    c = 16'h0000;
    rxq.delete();
    n_done = 0;
    @(negedge sys_clk_i);
    blk_len = 12'h004;
    @(negedge sys_clk_i);
    arm = 1'b1;
    host_u.sel();
    host_u.byte_x(bad ? 8'hFE : 8'hFC, b);
    for (int i = 0; i < 4; i++) begin
      host_u.byte_x(pat(8'(i + 9)), b);
      c = host_u.crc_byte(c, pat(8'(i + 9)));
    end
    host_u.byte_x(c[15:8], b);
    host_u.byte_x(c[7:0] ^ {7'h00, bad}, b);
    host_u.desel();
    @(negedge sys_clk_i);
    arm = 1'b0;
    chk8(8'(n_done), 8'h01);
    chk8(8'(rxq.size()), 8'h04);
    for (int i = 0; i < 4; i++) begin
      chk8(rxq[i], pat(8'(i + 9)));
    end
    chk8({7'h00, ok_seen}, {7'h00, !bad});
  endtask

  task automatic close_out;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    rst_b_i = 1'b0;
    err_set = '0;
    idle = 1'b1;
    locked = 1'b0;
    req = 1'b0;
    kind = CST_K_R1;
    blk_len = 12'h200;
    arm = 1'b0;
    rd_cnt = 8'h00;
    ok_seen = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    cycles = 0;
    n_done = 0;
    // link clock must run while reset is low
    fork
      host_u.idle(6);
      repeat (8) @(negedge sys_clk_i);
    join
    @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    host_u.idle(3);
    t_r1();
    t_r2();
    t_err();
    t_data(12'h001);
    t_data(12'h005);
    t_write(1'b0);
    t_write(1'b1);
    close_out();
  end
endmodule
